// ===== rtl/adil_pkg.sv
package adil_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_X_LO    = 8'h02;
  localparam logic [7:0] ADDR_STS1    = 8'h09;
  localparam logic [7:0] ADDR_STS2    = 8'h0a;
  localparam logic [7:0] ADDR_RANGE   = 8'h0f;
  localparam logic [7:0] ADDR_BW      = 8'h10;
  localparam logic [7:0] ADDR_DSET    = 8'h13;
  localparam logic [7:0] ADDR_SLOPE_AXIS_ENABLES  = 8'h16;
  localparam logic [7:0] ADDR_NEW_SAMPLE_IRQ_ENABLE  = 8'h17;
  localparam logic [7:0] ADDR_MAP     = 8'h1a;
  localparam logic [7:0] ADDR_PINCFG  = 8'h20;
  localparam logic [7:0] ADDR_LATCH   = 8'h21;
  localparam logic [7:0] ADDR_SIGMOT  = 8'h2a;

  // Field positions
  localparam int DSET_ENG_SRC_BIT   = 5;
  localparam int DSET_GUARD_OFF_BIT = 6;
  localparam int DSET_OUT_SRC_BIT   = 7;
  localparam int NEW_SAMPLE_IRQ_ENABLE_NEW_BIT     = 4;
  localparam int SIGMOT_MOVE_BIT    = 1;
  localparam int SIGMOT_MAJOR_BIT   = 2;
  localparam int STS2_WMARK_BIT     = 5;
  localparam int STS2_FULL_BIT      = 6;
  localparam int STS2_NEW_BIT       = 7;
  localparam int MAP_SLOPE_BIT      = 0;
  localparam int MAP_MAJOR_BIT      = 1;
  localparam int MAP_NEW_BIT        = 2;
  localparam int MAP_FIFO_BIT       = 3;
  localparam int MAP_PIN_B_OFS      = 4;
  localparam int PINCFG_A_HIGH_BIT  = 0;
  localparam int PINCFG_A_OD_BIT    = 1;
  localparam int PINCFG_B_HIGH_BIT  = 2;
  localparam int PINCFG_B_OD_BIT    = 3;
  localparam int LATCH_RST_BIT      = 7;

  // Codes
  localparam logic [3:0] RANGE_2G      = 4'h3;
  localparam logic [3:0] RANGE_4G      = 4'h5;
  localparam logic [3:0] RANGE_8G      = 4'h8;
  localparam logic [3:0] LATCH_NONE_A  = 4'h0;
  localparam logic [3:0] LATCH_NONE_B  = 4'h8;
  localparam logic [3:0] LATCH_HOLD_A  = 4'h7;
  localparam logic [3:0] LATCH_HOLD_B  = 4'hf;
  localparam logic [4:0] BW_CODE_MIN   = 5'h08;
  localparam logic [4:0] BW_CODE_MAX   = 5'h0f;

  // Reset values
  localparam logic [3:0] RANGE_RST = RANGE_2G;
  localparam logic [4:0] BW_RST    = BW_CODE_MAX;

  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int UNF_PERIOD_NS  = 500_000;
  localparam int NEW_HOLD_NS    = 250_000;
  localparam int TEMP_SHORT_NS  = 250_000;
  localparam int TEMP_MID_NS    = 12_500_000;
  localparam int TEMP_LONG_NS   = 250_000_000;
  localparam int UNF_CYC        = UNF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NEW_HOLD_CYC   = NEW_HOLD_NS / CLK_PERIOD_NS;
  localparam int TEMP_SHORT_CYC = TEMP_SHORT_NS / CLK_PERIOD_NS;
  localparam int TEMP_MID_CYC   = TEMP_MID_NS / CLK_PERIOD_NS;
  localparam int TEMP_LONG_CYC  = TEMP_LONG_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [27:0]       pre;
    logic [6:0]        dec;
    logic [2:0][11:0]  smp;
    logic [2:0][7:0]   hi;
    logic [2:0]        fresh;
    logic [3:0]        range;
    logic [4:0]        bw;
    logic [7:0]        dset;
    logic [7:0]        slope_axis_enables;
    logic [7:0]        new_sample_irq_enable;
    logic [7:0]        map;
    logic [7:0]        pincfg;
    logic [3:0]        latch;
    logic [7:0]        sigmot;
    logic [4:0]        mot_sts;
    logic [27:0]       mot_tmr;
    logic              new_sts;
    logic [27:0]       new_tmr;
    logic [1:0]        fifo_sts;
    logic [7:0]        rdata;
    logic              pin_a;
    logic              pin_a_oe;
    logic              pin_b;
    logic              pin_b_oe;
  } adil_state_t;

  // Pins idle high, driven: default is push-pull active-low
  localparam adil_state_t ADIL_STATE_RST = '{range: RANGE_RST, bw: BW_RST,
                                             pin_a: 1'b1, pin_a_oe: 1'b1,
                                             pin_b: 1'b1, pin_b_oe: 1'b1,
                                             default: '0};

endpackage : adil_pkg

// ===== rtl/adil_accel_irq.sv
`timescale 1ns/100ps
module adil_accel_irq
  import adil_pkg::*;
#(
  parameter int UNF_CYC_P        = adil_pkg::UNF_CYC,
  parameter int NEW_HOLD_CYC_P   = adil_pkg::NEW_HOLD_CYC,
  parameter int TEMP_SHORT_CYC_P = adil_pkg::TEMP_SHORT_CYC,
  parameter int TEMP_MID_CYC_P   = adil_pkg::TEMP_MID_CYC,
  parameter int TEMP_LONG_CYC_P  = adil_pkg::TEMP_LONG_CYC
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  input  wire logic [2:0][11:0] filt_sample_i,
  input  wire logic [2:0][11:0] raw_sample_i,
  input  wire logic [2:0]       slope_det_i,
  input  wire logic [2:0]       major_det_i,
  input  wire logic             fifo_wmark_i,
  input  wire logic             fifo_full_i,
  output logic      [3:0]       fullscale_code_o,
  output logic                  engine_unfiltered_o,
  output logic                  irq_pin_a_o,
  output logic                  irq_pin_a_oe_o,
  output logic                  irq_pin_b_o,
  output logic                  irq_pin_b_oe_o
);
  import adil_pkg::*;

  adil_state_t s_q;
  adil_state_t s_d;

  function automatic logic [27:0] hold_cycles(input logic [3:0] code);
    logic [27:0] r;
    r = 28'(TEMP_SHORT_CYC_P);
    if (code >= 4'h1 && code <= 4'h6)
    begin
      r = 28'(TEMP_LONG_CYC_P << (code - 4'h1));
    end
    else if (code >= 4'h9 && code <= 4'hb)
    begin
      r = 28'(TEMP_SHORT_CYC_P << (code - 4'h9));
    end
    else if (code >= 4'hc && code <= 4'he)
    begin
      r = 28'(TEMP_MID_CYC_P << (code - 4'hc));
    end
    return r;
  endfunction : hold_cycles

  function automatic logic [1:0] drive_pin(input logic lvl, input logic high, input logic od);
    logic p;
    p = high ? lvl : ~lvl;
    // Open-drain only ever pulls low; high level is left to the pull-up
    return od ? {1'b0, ~p} : {p, 1'b1};
  endfunction : drive_pin

  logic              unf_tick;
  logic              filt_tick;
  logic              upd;
  logic              guard_off;
  logic [2:0]        k;
  logic [4:0]        bw_eff;
  logic [6:0]        mask;
  logic [2:0][11:0]  val;
  logic [2:0]        axis_en;
  logic [4:0]        cond;
  logic              irq_rst;
  logic              rd_lo;
  logic              rd_hi;
  logic [3:0]        src;
  logic [1:0]        pa;
  logic [1:0]        pb;

  always_comb
  begin
    s_d = s_q;

    // Prescaler gives the 2 kHz unfiltered rate
    unf_tick = (s_q.pre == 28'(UNF_CYC_P - 1));
    s_d.pre  = unf_tick ? 28'h0 : s_q.pre + 28'h1;
    if (unf_tick)
    begin
      s_d.dec = s_q.dec + 7'h1;
    end
    bw_eff = s_q.bw[4] ? BW_CODE_MAX : ((s_q.bw < BW_CODE_MIN) ? BW_CODE_MIN : s_q.bw);
    k      = 3'(BW_CODE_MAX - bw_eff);
    mask   = 7'h7f >> (3'h7 - k);
    // Filtered rate is 2 kHz divided by 2^k, i.e. twice the bandwidth
    filt_tick = unf_tick && ((s_q.dec & mask) == 7'h0);

    upd       = s_q.dset[DSET_OUT_SRC_BIT] ? unf_tick : filt_tick;
    val       = s_q.dset[DSET_OUT_SRC_BIT] ? raw_sample_i : filt_sample_i;
    guard_off = s_q.dset[DSET_GUARD_OFF_BIT];

    if (reg_rd_i)
    begin
      s_d.rdata = 8'h00;
    end

    for (int i = 0; i < 3; i++)
    begin
      rd_lo = reg_rd_i && (reg_addr_i == ADDR_X_LO + 8'(2 * i));
      rd_hi = reg_rd_i && (reg_addr_i == ADDR_X_LO + 8'(2 * i + 1));
      if (rd_lo)
      begin
        s_d.rdata = {s_q.smp[i][3:0], 3'b000, s_q.fresh[i]};
        if (!guard_off)
        begin
          s_d.hi[i] = s_q.smp[i][11:4];
        end
      end
      if (rd_hi)
      begin
        s_d.rdata = s_q.hi[i];
      end
      if (rd_lo || rd_hi)
      begin
        s_d.fresh[i] = 1'b0;
      end
      if (upd)
      begin
        s_d.smp[i]   = val[i];
        s_d.fresh[i] = 1'b1;
        if (guard_off)
        begin
          s_d.hi[i] = val[i][11:4];
        end
      end
    end

    // Motion conditions
    axis_en = s_q.slope_axis_enables[2:0];
    cond[2:0] = slope_det_i & axis_en;
    cond[3]   = s_q.sigmot[SIGMOT_MOVE_BIT] && |(slope_det_i & axis_en);
    cond[4]   = s_q.sigmot[SIGMOT_MAJOR_BIT] && |(major_det_i & axis_en);

    irq_rst = reg_wr_i && (reg_addr_i == ADDR_LATCH) && reg_wdata_i[LATCH_RST_BIT];
    if (s_q.latch == LATCH_NONE_A || s_q.latch == LATCH_NONE_B)
    begin
      s_d.mot_sts = cond;
      s_d.mot_tmr = 28'h0;
    end
    else if (s_q.latch == LATCH_HOLD_A || s_q.latch == LATCH_HOLD_B)
    begin
      s_d.mot_sts = irq_rst ? cond : (s_q.mot_sts | cond);
      s_d.mot_tmr = 28'h0;
    end
    else
    begin
      // One shared hold timer: later bits clear with the first one
      if (s_q.mot_tmr != 28'h0)
      begin
        s_d.mot_tmr = s_q.mot_tmr - 28'h1;
      end
      if (s_q.mot_tmr == 28'h1)
      begin
        // A condition present at expiry starts a fresh hold: set wins
        s_d.mot_sts = cond;
        if (cond != 5'h00)
        begin
          s_d.mot_tmr = hold_cycles(s_q.latch);
        end
      end
      else
      begin
        s_d.mot_sts = s_q.mot_sts | cond;
        if (s_q.mot_sts == 5'h00 && cond != 5'h00)
        begin
          s_d.mot_tmr = hold_cycles(s_q.latch);
        end
      end
    end

    // New-sample status: fixed hold, set wins over expiry
    if (s_q.new_tmr != 28'h0)
    begin
      s_d.new_tmr = s_q.new_tmr - 28'h1;
    end
    if (s_q.new_tmr == 28'h1)
    begin
      s_d.new_sts = 1'b0;
    end
    if (upd && s_q.new_sample_irq_enable[NEW_SAMPLE_IRQ_ENABLE_NEW_BIT])
    begin
      s_d.new_sts = 1'b1;
      s_d.new_tmr = 28'(NEW_HOLD_CYC_P);
    end
    s_d.fifo_sts = {fifo_full_i, fifo_wmark_i};

    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ADDR_STS1:   s_d.rdata = {3'b000, s_q.mot_sts};
        ADDR_STS2:   s_d.rdata = {s_q.new_sts, s_q.fifo_sts, 5'h00};
        ADDR_RANGE:  s_d.rdata = {4'h0, s_q.range};
        ADDR_BW:     s_d.rdata = {3'b000, s_q.bw};
        ADDR_DSET:   s_d.rdata = s_q.dset;
        ADDR_SLOPE_AXIS_ENABLES: s_d.rdata = s_q.slope_axis_enables;
        ADDR_NEW_SAMPLE_IRQ_ENABLE: s_d.rdata = s_q.new_sample_irq_enable;
        ADDR_MAP:    s_d.rdata = s_q.map;
        ADDR_PINCFG: s_d.rdata = s_q.pincfg;
        ADDR_LATCH:  s_d.rdata = {4'h0, s_q.latch};
        ADDR_SIGMOT: s_d.rdata = s_q.sigmot;
        default:     ;
      endcase
    end

    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        ADDR_RANGE:  s_d.range  = reg_wdata_i[3:0];
        ADDR_BW:     s_d.bw     = reg_wdata_i[4:0];
        ADDR_DSET:   s_d.dset   = reg_wdata_i;
        ADDR_SLOPE_AXIS_ENABLES: s_d.slope_axis_enables = reg_wdata_i;
        ADDR_NEW_SAMPLE_IRQ_ENABLE: s_d.new_sample_irq_enable = reg_wdata_i;
        ADDR_MAP:    s_d.map    = reg_wdata_i;
        ADDR_PINCFG: s_d.pincfg = reg_wdata_i;
        ADDR_LATCH:  s_d.latch  = reg_wdata_i[3:0];
        ADDR_SIGMOT: s_d.sigmot = reg_wdata_i;
        default:     ;
      endcase
    end

    // Pins from the next-state statuses so pin and status move together
    src[MAP_SLOPE_BIT] = |s_d.mot_sts[3:0];
    src[MAP_MAJOR_BIT] = s_d.mot_sts[4];
    src[MAP_NEW_BIT]   = s_d.new_sts;
    src[MAP_FIFO_BIT]  = |s_d.fifo_sts;
    pa = drive_pin(|(src & s_q.map[3:0]), s_q.pincfg[PINCFG_A_HIGH_BIT],
                   s_q.pincfg[PINCFG_A_OD_BIT]);
    pb = drive_pin(|(src & s_q.map[MAP_PIN_B_OFS +: 4]), s_q.pincfg[PINCFG_B_HIGH_BIT],
                   s_q.pincfg[PINCFG_B_OD_BIT]);
    s_d.pin_a    = pa[1];
    s_d.pin_a_oe = pa[0];
    s_d.pin_b    = pb[1];
    s_d.pin_b_oe = pb[0];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= ADIL_STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o         = s_q.rdata;
  assign fullscale_code_o    = s_q.range;
  assign engine_unfiltered_o = s_q.dset[DSET_ENG_SRC_BIT];
  assign irq_pin_a_o         = s_q.pin_a;
  assign irq_pin_a_oe_o      = s_q.pin_a_oe;
  assign irq_pin_b_o         = s_q.pin_b;
  assign irq_pin_b_oe_o      = s_q.pin_b_oe;

endmodule : adil_accel_irq

// ===== verif/adil_accel_irq_asserts.sv
`timescale 1ns/100ps
module adil_accel_irq_chk
  import adil_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       fifo_wmark_i,
  input wire logic       fifo_full_i,
  input wire logic [3:0] fullscale_code_o,
  input wire logic       engine_unfiltered_o,
  input wire logic       irq_pin_a_o,
  input wire logic       irq_pin_a_oe_o,
  input wire logic       irq_pin_b_o,
  input wire logic       irq_pin_b_oe_o
);
  logic [7:0] map_q;
  logic [7:0] pcfg_q;

  // Shadows of routing and pin setup, so pin checks know the mode
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) {map_q, pcfg_q} <= 16'h0000;
    else if (reg_wr_i && reg_addr_i == ADDR_MAP) map_q <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == ADDR_PINCFG) pcfg_q <= reg_wdata_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_range_write: assert property (
    reg_wr_i && reg_addr_i == ADDR_RANGE |=> fullscale_code_o == $past(reg_wdata_i[3:0]))
    else $error("range output differs from written code");
  chk_engine_sel: assert property (
    reg_wr_i && reg_addr_i == ADDR_DSET |=> engine_unfiltered_o == $past(reg_wdata_i[5]))
    else $error("engine source differs from written bit");
  chk_latch_rd: assert property (
    reg_rd_i && reg_addr_i == ADDR_LATCH |=> !reg_rdata_o[LATCH_RST_BIT])
    else $error("latch reset bit reads back as one");
  chk_od_a_low: assert property (!irq_pin_a_oe_o |-> !irq_pin_a_o)
    else $error("pin a released with high value");
  chk_od_b_low: assert property (!irq_pin_b_oe_o |-> !irq_pin_b_o)
    else $error("pin b released with high value");
  chk_fifo_or_a: assert property (
    map_q[3:0] == 4'h8 && pcfg_q[1:0] == 2'h1 && !reg_wr_i
    |=> irq_pin_a_o == $past(fifo_wmark_i | fifo_full_i))
    else $error("pin a does not follow buffer conditions");
  chk_idle_pin_a: assert property (
    map_q[3:0] == 4'h0 && pcfg_q[1:0] == 2'h0 && !reg_wr_i |=> irq_pin_a_o && irq_pin_a_oe_o)
    else $error("unmapped pin a not idle high");
  chk_fifo_sts: assert property (
    reg_rd_i && reg_addr_i == ADDR_STS2 && $stable({fifo_full_i, fifo_wmark_i})
    |=> reg_rdata_o[6:5] == $past({fifo_full_i, fifo_wmark_i}))
    else $error("buffer status bits differ from conditions");
endmodule : adil_accel_irq_chk

bind adil_accel_irq adil_accel_irq_chk chk_u (.*);

// ===== verif/adil_host_model.sv
`timescale 1ns/100ps
module adil_host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  initial {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h00000;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    #1;
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, v, 1'b1};
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    #1;
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(posedge clk_i);
    #1;
    v = reg_rdata_i;
    reg_rd_o = 1'b0;
  endtask : rd

  // Low byte first, so the guard hands over the matching high byte
  task automatic rd_smp(input int ax, output logic [11:0] s, output logic nf);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(8'(2 + 2 * ax), lo);
    rd(8'(3 + 2 * ax), hi);
    s = {hi, lo[7:4]};
    nf = lo[0];
  endtask : rd_smp
endmodule : adil_host_model

// ===== verif/adil_accel_irq_tb_top.sv
`timescale 1ns/100ps
module adil_accel_irq_tb_top;
  import adil_pkg::*;
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, fifo_wmark_i, fifo_full_i, nf;
  logic engine_unfiltered_o, irq_pin_a_o, irq_pin_a_oe_o, irq_pin_b_o, irq_pin_b_oe_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [2:0][11:0] filt_sample_i, raw_sample_i;
  logic [2:0] slope_det_i, major_det_i;
  logic [3:0] fullscale_code_o;
  logic [11:0] s;
  int mismatches, cmp_count, n;
  // Pull-up on both lines
  wire pin_a = irq_pin_a_oe_o ? irq_pin_a_o : 1'b1;
  wire pin_b = irq_pin_b_oe_o ? irq_pin_b_o : 1'b1;

  adil_accel_irq #(.UNF_CYC_P(20), .NEW_HOLD_CYC_P(8), .TEMP_SHORT_CYC_P(4),
    .TEMP_MID_CYC_P(16), .TEMP_LONG_CYC_P(32)) dut_u (.clk_i, .rst_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .filt_sample_i, .raw_sample_i,
    .slope_det_i, .major_det_i, .fifo_wmark_i, .fifo_full_i, .fullscale_code_o,
    .engine_unfiltered_o, .irq_pin_a_o, .irq_pin_a_oe_o, .irq_pin_b_o, .irq_pin_b_oe_o);
  adil_host_model host_u (.clk_i, .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc

  // Counts cycles until the next rise of pin a
  task automatic wait_rise(output int k);
    k = 0;
    while (pin_a !== 1'b0 && k < 100) begin cyc(1); k++; end
    while (pin_a !== 1'b1 && k < 200) begin cyc(1); k++; end
  endtask : wait_rise

  task automatic t_regs;
    logic [3:0] codes [3] = '{RANGE_2G, RANGE_4G, RANGE_8G};
    host_u.rd(ADDR_RANGE, d); chk(d, 12'h003);
    host_u.rd(ADDR_BW, d); chk(d, 12'h00f);
    host_u.rd(8'h01, d); chk(d, 12'h000);
    chk(pin_a, 12'h001);
    foreach (codes[i])
    begin
      host_u.wr(ADDR_RANGE, {4'h0, codes[i]});
      chk(fullscale_code_o, codes[i]);
    end
    host_u.wr(ADDR_DSET, 8'h20); chk(engine_unfiltered_o, 12'h001);
    $display("test regs done");
  endtask : t_regs

  task automatic t_data;
    raw_sample_i = {12'h800, 12'h7ff, 12'h9ab};
    filt_sample_i = {3{12'h5a5}};
    host_u.wr(ADDR_MAP, 8'h04);
    host_u.wr(ADDR_PINCFG, 8'h01);
    host_u.wr(ADDR_DSET, 8'h80);
    host_u.wr(ADDR_NEW_SAMPLE_IRQ_ENABLE, 8'h10);
    wait_rise(n);
    for (int a = 0; a < 3; a++)
    begin
      host_u.rd_smp(a, s, nf);
      chk(s, raw_sample_i[a]);
      chk(nf, 12'h001);
    end
    host_u.rd(8'h02, d); chk(d[0], 12'h000);
    cyc(4); chk(pin_a, 12'h000);
    raw_sample_i[0] = 12'h123;
    wait_rise(n);
    host_u.rd(8'h03, d); chk(d, 12'h09a);
    host_u.rd_smp(0, s, nf); chk(s, 12'h123);
    host_u.wr(ADDR_DSET, 8'hc0);
    raw_sample_i[0] = 12'h456;
    wait_rise(n);
    host_u.rd(8'h03, d); chk(d, 12'h045);
    host_u.wr(ADDR_DSET, 8'h00);
    wait_rise(n);
    host_u.rd_smp(0, s, nf); chk(s, 12'h5a5);
    wait_rise(n); wait_rise(n); chk(n, 12'd20);
    host_u.wr(ADDR_BW, 8'h0e);
    wait_rise(n); wait_rise(n); chk(n, 12'd40);
    $display("test data done");
  endtask : t_data

  task automatic t_fifo;
    host_u.wr(ADDR_MAP, 8'h88);
    host_u.wr(ADDR_PINCFG, 8'h05);
    fifo_wmark_i = 1'b1; cyc(2);
    chk({pin_b, pin_a}, 12'h003);
    host_u.rd(ADDR_STS2, d); chk(d[6:5], 12'h001);
    {fifo_wmark_i, fifo_full_i} = 2'b01; cyc(2);
    host_u.rd(ADDR_STS2, d); chk(d[6:5], 12'h002);
    fifo_full_i = 1'b0; cyc(2); chk(pin_a, 12'h000);
    host_u.wr(ADDR_PINCFG, 8'h02); cyc(1); chk(pin_a, 12'h001);
    fifo_full_i = 1'b1; cyc(2); chk({irq_pin_a_oe_o, pin_a}, 12'h002);
    fifo_full_i = 1'b0; cyc(2);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_slope;
    host_u.wr(ADDR_MAP, 8'h01);
    host_u.wr(ADDR_PINCFG, 8'h01);
    host_u.wr(ADDR_SLOPE_AXIS_ENABLES, 8'h01);
    slope_det_i = 3'b010; cyc(2); chk(pin_a, 12'h000);
    slope_det_i = 3'b011; cyc(2); chk(pin_a, 12'h001);
    host_u.rd(ADDR_STS1, d); chk(d[2:0], 12'h001);
    slope_det_i = 3'b000; cyc(2); chk(pin_a, 12'h000);
    host_u.wr(ADDR_LATCH, 8'h07);
    slope_det_i = 3'b001; cyc(2); slope_det_i = 3'b000; cyc(3);
    chk(pin_a, 12'h001);
    host_u.rd(ADDR_LATCH, d); chk(d, 12'h007);
    host_u.wr(ADDR_LATCH, 8'h87); cyc(1); chk(pin_a, 12'h000);
    host_u.wr(ADDR_LATCH, 8'h09);
    slope_det_i = 3'b001; cyc(1); slope_det_i = 3'b000;
    cyc(2); chk(pin_a, 12'h001);
    cyc(1); chk(pin_a, 12'h001);
    cyc(1); chk(pin_a, 12'h000);
    $display("test slope done");
  endtask : t_slope

  // One z-axis major event in temporary mode; pin b high for exactly len cycles
  task automatic hold_chk(input logic [3:0] code, input int len);
    host_u.wr(ADDR_LATCH, {4'h0, code});
    major_det_i = 3'b100; cyc(1); major_det_i = 3'b000;
    cyc(len - 1); chk(pin_b, 12'h001);
    cyc(1); chk(pin_b, 12'h000);
  endtask : hold_chk

  task automatic t_motion;
    host_u.wr(ADDR_MAP, 8'h20);
    host_u.wr(ADDR_PINCFG, 8'h04);
    host_u.wr(ADDR_SLOPE_AXIS_ENABLES, 8'h06);
    host_u.wr(ADDR_SIGMOT, 8'h06);
    host_u.wr(ADDR_LATCH, 8'h08);
    major_det_i = 3'b001; cyc(2); chk(pin_b, 12'h000);
    major_det_i = 3'b100; cyc(2); chk(pin_b, 12'h001);
    slope_det_i = 3'b010;
    host_u.rd(ADDR_STS1, d); chk(d, 12'h01a);
    chk(pin_a, 12'h001);
    {major_det_i, slope_det_i} = 6'h00; cyc(2); chk(pin_b, 12'h000);
    hold_chk(4'h2, 64);
    hold_chk(4'hc, 16);
    host_u.wr(ADDR_LATCH, 8'h0f);
    {major_det_i, slope_det_i} = 6'h22; cyc(1); slope_det_i = 3'b000;
    cyc(2); chk(pin_b, 12'h001);
    host_u.rd(ADDR_STS1, d); chk(d, 12'h01a);
    host_u.wr(ADDR_LATCH, 8'h8f); cyc(1); chk(pin_b, 12'h001);
    host_u.rd(ADDR_STS1, d); chk(d, 12'h010);
    major_det_i = 3'b000;
    host_u.wr(ADDR_LATCH, 8'h8f); cyc(1); chk(pin_b, 12'h000);
    $display("test motion done");
  endtask : t_motion

  // Left in latched mode: the new-sample pulse must still clear on its own
  task automatic t_rate;
    host_u.wr(ADDR_MAP, 8'h04);
    host_u.wr(ADDR_PINCFG, 8'h01);
    host_u.wr(ADDR_BW, 8'h1c);
    wait_rise(n); wait_rise(n); chk(n, 12'd20);
    host_u.rd(ADDR_BW, d); chk(d, 12'h01c);
    $display("test rate done");
  endtask : t_rate

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    {rst_i, fifo_wmark_i, fifo_full_i, slope_det_i, major_det_i} = 9'h100;
    {filt_sample_i, raw_sample_i} = '0;
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_regs;
    t_data;
    t_fifo;
    t_slope;
    t_motion;
    t_rate;
    give_verdict;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #1_000_000;
    mismatches++;
    give_verdict;
  end
endmodule : adil_accel_irq_tb_top
